// ===== core/pdcc_power_capture.sv
// Captures slot power limit value and scale from received messages
`timescale 1ns/1ns
`default_nettype none
`include "pdcc_params.svh"
module pdcc_power_capture #(
   parameter int VAL_W = 8
) (
   input  wire logic                     clk,
   input  wire logic                     rst,
   input  wire pdcc_pkg::pdcc_port_mode_t port_mode,
   input  wire logic                     msg_valid,
   input  wire logic [VAL_W-1:0]         msg_value,
   input  wire pdcc_pkg::pdcc_scale_t    msg_scale,
   output logic      [VAL_W-1:0]         cap_value,
   output pdcc_pkg::pdcc_scale_t         cap_scale,
   output logic                          cap_event
);
   logic [VAL_W-1:0]      value_reg;
   pdcc_pkg::pdcc_scale_t scale_reg;
   logic                  event_reg;
   logic                  upstream;

   assign upstream = (port_mode == pdcc_pkg::PDCC_PORT_UPSTREAM);

   // Load on a message to any function of the port, upstream only
   always_ff @(posedge clk) begin
      if (rst) begin
         value_reg <= '0;
         scale_reg <= pdcc_pkg::PDCC_SCALE_1_0;
      end else if (!upstream) begin
         value_reg <= '0;
         scale_reg <= pdcc_pkg::PDCC_SCALE_1_0;
      end else if (msg_valid) begin
         value_reg <= msg_value;
         scale_reg <= msg_scale;
      end
   end

   // One-cycle pulse when a message is taken
   always_ff @(posedge clk) begin
      if (rst) begin
         event_reg <= 1'b0;
      end else begin
         event_reg <= msg_valid && upstream;
      end
   end

   assign cap_value = value_reg;
   assign cap_scale = scale_reg;
   assign cap_event = event_reg;

   a_unattached_hold: assert property (
      @(posedge clk) disable iff (rst)
      port_mode == pdcc_pkg::PDCC_PORT_UNATTACHED |=> value_reg == '0
      && scale_reg == pdcc_pkg::PDCC_SCALE_1_0)
      else $error("captured fields not zero in unattached mode");
   a_upstream_load: assert property (
      @(posedge clk) disable iff (rst)
      msg_valid && upstream ##1 upstream |-> value_reg == $past(msg_value)
      && scale_reg == $past(msg_scale))
      else $error("message not loaded on upstream port");
endmodule
`default_nettype wire

// ===== core/pdcc_regs.sv
// Device capability and device control register bank of a switch port
// Operation
// - Attention indicator present bit 13 is read-only zero.
// - Power indicator present bit 14 is read-only zero.
// - Role-based error reporting bit 15 is read-only one.
// - Captured power value sits in bits 25:18, read-only, reset zero.
// - Slot power limit is the captured value times the scale factor.
// - An upstream port loads value and scale from a received message.
// - Captured scale sits in bits 27:26, codes 1.0, 0.1, 0.01, 0.001.
// - An unattached port clears the captured fields to zero.
// - Downstream and unattached ports read the captured fields as zero.
// - A power limit message applies to every function in the port.
// - Control bit 0 enables correctable error reporting, reset zero.
// - Control bit 1 enables non-fatal error reporting, reset zero.
// - Control bit 2 enables fatal error reporting, reset zero.
// - Error detected flags set whether or not reporting is enabled.
`timescale 1ns/1ns
`default_nettype none
`include "pdcc_params.svh"
module pdcc_regs #(
   parameter int VAL_W = 8
) (
   input  wire logic                      clk,
   input  wire logic                      rst,
   input  wire logic [`PDCC_ADDR_W-1:0]   reg_addr,
   input  wire logic [31:0]               reg_wdata,
   input  wire logic                      reg_wr,
   input  wire logic                      reg_rd,
   output logic      [31:0]               reg_rdata,
   input  wire pdcc_pkg::pdcc_port_mode_t port_mode,
   input  wire logic                      msg_valid,
   input  wire logic [VAL_W-1:0]          msg_value,
   input  wire pdcc_pkg::pdcc_scale_t     msg_scale,
   input  wire logic [2:0]                err_event,
   output logic      [2:0]                err_report,
   output logic      [VAL_W-1:0]          power_limit_value,
   output pdcc_pkg::pdcc_scale_t          power_limit_scale,
   output logic                           irq
);
   logic [31:0]           rdata_reg;
   logic [2:0]            ctl_reg;
   logic [2:0]            sts_reg;
   logic [3:0]            mask_reg;
   logic [2:0]            report_reg;
   logic                  irq_reg;
   logic                  pwr_evt_reg;
   logic [VAL_W-1:0]      cap_value;
   pdcc_pkg::pdcc_scale_t cap_scale;
   logic                  cap_event;
   logic [31:0]           devcap_word;

   // Address match used by both the write and the read decoders
   function automatic logic hit(input logic [`PDCC_ADDR_W-1:0] a,
                                input logic [`PDCC_ADDR_W-1:0] off);
      hit = (a == off);
   endfunction

   pdcc_power_capture #(
      .VAL_W     (VAL_W)
   ) u_capture (
      .clk       (clk),
      .rst       (rst),
      .port_mode (port_mode),
      .msg_valid (msg_valid),
      .msg_value (msg_value),
      .msg_scale (msg_scale),
      .cap_value (cap_value),
      .cap_scale (cap_scale),
      .cap_event (cap_event)
   );

   // Capability word: fixed bits, reserved zero, captured power fields
   always_comb begin
      devcap_word = 32'h0000_0000;
      devcap_word[12:0] = `PDCC_DEVCAP_LOW;
      devcap_word[`PDCC_BIT_ATTN] = 1'b0;
      devcap_word[`PDCC_BIT_PWRIND] = 1'b0;
      devcap_word[`PDCC_BIT_ROLE_BASED_ERR_SUPPORT] = `PDCC_ROLE_BASED_ERR_SUPPORT_RST;
      devcap_word[`PDCC_VAL_MSB:`PDCC_VAL_LSB] = cap_value;
      devcap_word[`PDCC_SCL_MSB:`PDCC_SCL_LSB] = cap_scale;
   end

   // Reporting enables, written by software
   always_ff @(posedge clk) begin
      if (rst) begin
         ctl_reg <= `PDCC_CTL_RST;
      end else if (reg_wr && hit(reg_addr, `PDCC_OFF_DEVCTL)) begin
         ctl_reg <= reg_wdata[2:0];
      end
   end

   // Detected-error flags, set by events, write one to clear, set wins
   always_ff @(posedge clk) begin
      if (rst) begin
         sts_reg <= `PDCC_STS_RST;
      end else begin
         if (reg_wr && hit(reg_addr, `PDCC_OFF_ERRSTS)) begin
            sts_reg <= (sts_reg & ~reg_wdata[2:0]) | err_event;
         end else begin
            sts_reg <= sts_reg | err_event;
         end
      end
   end

   // Power message flag shares status bit 3
   always_ff @(posedge clk) begin
      if (rst) begin
         pwr_evt_reg <= 1'b0;
      end else if (cap_event) begin
         pwr_evt_reg <= 1'b1;
      end else if (reg_wr && hit(reg_addr, `PDCC_OFF_ERRSTS)
                   && reg_wdata[3]) begin
         pwr_evt_reg <= 1'b0;
      end
   end

   // Interrupt mask
   always_ff @(posedge clk) begin
      if (rst) begin
         mask_reg <= {1'b0, `PDCC_MASK_RST};
      end else if (reg_wr && hit(reg_addr, `PDCC_OFF_IRQMASK)) begin
         mask_reg <= reg_wdata[3:0];
      end
   end

   // Error report pulses gated by enables
   always_ff @(posedge clk) begin
      if (rst) begin
         report_reg <= 3'h0;
      end else begin
         report_reg <= err_event & ctl_reg;
      end
   end

   // Level interrupt from unmasked sticky flags
   always_ff @(posedge clk) begin
      if (rst) begin
         irq_reg <= 1'b0;
      end else begin
         irq_reg <= |({pwr_evt_reg, sts_reg} & mask_reg);
      end
   end

   // Read data, valid the cycle after the read strobe
   always_ff @(posedge clk) begin
      if (rst) begin
         rdata_reg <= 32'h0000_0000;
      end else if (reg_rd) begin
         if (hit(reg_addr, `PDCC_OFF_DEVCAP)) begin
            rdata_reg <= devcap_word;
         end else if (hit(reg_addr, `PDCC_OFF_DEVCTL)) begin
            rdata_reg <= {29'h0000_0000, ctl_reg};
         end else if (hit(reg_addr, `PDCC_OFF_ERRSTS)) begin
            rdata_reg <= {28'h000_0000, pwr_evt_reg, sts_reg};
         end else if (hit(reg_addr, `PDCC_OFF_IRQMASK)) begin
            rdata_reg <= {28'h000_0000, mask_reg};
         end else if (hit(reg_addr, `PDCC_OFF_PORTSTAT)) begin
            rdata_reg <= {30'h0000_0000, port_mode};
         end else begin
            rdata_reg <= 32'h0000_0000;
         end
      end else begin
         rdata_reg <= 32'h0000_0000;
      end
   end

   // Limit in watts is value times the scale factor, left to the user
   assign power_limit_value = cap_value;
   assign power_limit_scale = cap_scale;
   assign reg_rdata = rdata_reg;
   assign err_report = report_reg;
   assign irq = irq_reg;

   // Fixed capability bits and reserved fields on every capability read
   a_fixed_bits: assert property (
      @(posedge clk) disable iff (rst)
      reg_rd && hit(reg_addr, `PDCC_OFF_DEVCAP) |=> reg_rdata[15:13] == 3'h4
      && reg_rdata[17:16] == 2'h0 && reg_rdata[31:28] == 4'h0)
      else $error("fixed capability bits wrong");

   // Low capability bits of this block read as zero
   a_low_cap: assert property (
      @(posedge clk) disable iff (rst)
      reg_rd && hit(reg_addr, `PDCC_OFF_DEVCAP) |=>
      reg_rdata[12:0] == `PDCC_DEVCAP_LOW)
      else $error("low capability bits nonzero");

   // Captured fields reach the capability word unchanged
   a_capture_read: assert property (
      @(posedge clk) disable iff (rst)
      reg_rd && hit(reg_addr, `PDCC_OFF_DEVCAP) |=>
      reg_rdata[25:18] == $past(cap_value)
      && reg_rdata[27:26] == $past(cap_scale))
      else $error("captured fields misread");

   // A tenth scale code is kept as code one
   a_scale_code: assert property (
      @(posedge clk) disable iff (rst)
      msg_valid && port_mode == pdcc_pkg::PDCC_PORT_UPSTREAM
      && msg_scale == pdcc_pkg::PDCC_SCALE_0_1 ##1
      port_mode == pdcc_pkg::PDCC_PORT_UPSTREAM |-> cap_scale == 2'h1)
      else $error("scale code not kept");

   // A port that stays downstream shows no captured power
   a_down_zero: assert property (
      @(posedge clk) disable iff (rst)
      port_mode == pdcc_pkg::PDCC_PORT_DOWNSTREAM ##1
      port_mode == pdcc_pkg::PDCC_PORT_DOWNSTREAM |->
      devcap_word[27:18] == 10'h000)
      else $error("captured fields nonzero downstream");

   // Enables, flags, mask and interrupt all leave reset cleared
   a_reset_clear: assert property (
      @(posedge clk)
      rst |=> ctl_reg == `PDCC_CTL_RST && sts_reg == `PDCC_STS_RST
      && mask_reg[2:0] == `PDCC_MASK_RST && !mask_reg[3]
      && report_reg == 3'h0 && !pwr_evt_reg && !irq)
      else $error("state not cleared by reset");

   // A control write is seen by a read on the next strobe
   a_ctl_write: assert property (
      @(posedge clk) disable iff (rst)
      reg_wr && hit(reg_addr, `PDCC_OFF_DEVCTL) ##1 !reg_wr ##0 reg_rd
      && hit(reg_addr, `PDCC_OFF_DEVCTL) |=>
      reg_rdata[2:0] == $past(reg_wdata[2:0], 2))
      else $error("control readback wrong");

   // Control read returns the enables with zero above them
   a_ctl_read: assert property (
      @(posedge clk) disable iff (rst)
      reg_rd && hit(reg_addr, `PDCC_OFF_DEVCTL) |=>
      reg_rdata == {29'h0000_0000, $past(ctl_reg)})
      else $error("control read wrong");

   // Correctable error is reported while its enable is set
   a_report_corr: assert property (
      @(posedge clk) disable iff (rst)
      err_event[0] && ctl_reg[0] |=> err_report[0])
      else $error("correctable not reported");

   // Non-fatal error stays unreported while its enable is clear
   a_report_gate: assert property (
      @(posedge clk) disable iff (rst)
      err_event[1] && !ctl_reg[1] |=> !err_report[1])
      else $error("non-fatal reported while disabled");

   // Fatal error is reported while its enable is set
   a_report_fatal: assert property (
      @(posedge clk) disable iff (rst)
      err_event[2] && ctl_reg[2] |=> err_report[2])
      else $error("fatal not reported");

   // Fatal error stays unreported while its enable is clear
   a_fatal_gate: assert property (
      @(posedge clk) disable iff (rst)
      err_event[2] && !ctl_reg[2] |=> !err_report[2])
      else $error("fatal reported while disabled");

   // Correctable flag holds unless software clears it
   a_flag_set: assert property (
      @(posedge clk) disable iff (rst)
      err_event[0] ##1 !(reg_wr && hit(reg_addr, `PDCC_OFF_ERRSTS)) |->
      sts_reg[0] [*2])
      else $error("detected flag lost");

   // Every error class sets its flag, enabled or not
   a_flag_any: assert property (
      @(posedge clk) disable iff (rst)
      (|err_event) |=> (sts_reg & $past(err_event)) == $past(err_event))
      else $error("detected flag not set");

   // A taken power message raises its flag
   a_pwr_flag: assert property (
      @(posedge clk) disable iff (rst)
      cap_event |=> pwr_evt_reg)
      else $error("power message flag not set");

   // Status read returns the flags as they stood
   a_status_read: assert property (
      @(posedge clk) disable iff (rst)
      reg_rd && hit(reg_addr, `PDCC_OFF_ERRSTS) |=>
      reg_rdata[3:0] == $past({pwr_evt_reg, sts_reg}))
      else $error("status readback wrong");

   // Mask read returns the mask as it stood
   a_mask_read: assert property (
      @(posedge clk) disable iff (rst)
      reg_rd && hit(reg_addr, `PDCC_OFF_IRQMASK) |=>
      reg_rdata[3:0] == $past(mask_reg))
      else $error("mask readback wrong");

   // Port status read returns the port mode
   a_port_read: assert property (
      @(posedge clk) disable iff (rst)
      reg_rd && hit(reg_addr, `PDCC_OFF_PORTSTAT) |=>
      reg_rdata == {30'h0000_0000, $past(port_mode)})
      else $error("port status read wrong");

   // Reads of unmapped addresses return zero
   a_unmapped_read: assert property (
      @(posedge clk) disable iff (rst)
      reg_rd && !hit(reg_addr, `PDCC_OFF_DEVCAP)
      && !hit(reg_addr, `PDCC_OFF_DEVCTL)
      && !hit(reg_addr, `PDCC_OFF_ERRSTS)
      && !hit(reg_addr, `PDCC_OFF_IRQMASK)
      && !hit(reg_addr, `PDCC_OFF_PORTSTAT) |=> reg_rdata == 32'h0000_0000)
      else $error("unmapped read nonzero");

   // Interrupt rises one cycle after an unmasked flag
   a_irq_raise: assert property (
      @(posedge clk) disable iff (rst)
      (|({pwr_evt_reg, sts_reg} & mask_reg)) |=> irq)
      else $error("interrupt missing");

   // Interrupt falls once no unmasked flag is left
   a_irq_drop: assert property (
      @(posedge clk) disable iff (rst)
      !(|({pwr_evt_reg, sts_reg} & mask_reg)) |=> !irq)
      else $error("interrupt stuck high");

   // Read data is zero outside the cycle after a read strobe
   a_rdata_idle: assert property (
      @(posedge clk) disable iff (rst)
      !reg_rd |=> reg_rdata == 32'h0000_0000)
      else $error("read data outside its cycle");
endmodule
`default_nettype wire

// ===== pkg/pdcc_params.svh
// Register offsets, field positions and reset values of the capability block
`ifndef PDCC_PARAMS_SVH
`define PDCC_PARAMS_SVH
`define PDCC_ADDR_W        12
`define PDCC_OFF_DEVCAP    12'h044
`define PDCC_OFF_DEVCTL    12'h048
`define PDCC_OFF_ERRSTS    12'h04c
`define PDCC_OFF_IRQMASK   12'h050
`define PDCC_OFF_PORTSTAT  12'h054
`define PDCC_BIT_ATTN      13
`define PDCC_BIT_PWRIND    14
`define PDCC_BIT_ROLE_BASED_ERR_SUPPORT     15
`define PDCC_VAL_LSB       18
`define PDCC_VAL_MSB       25
`define PDCC_SCL_LSB       26
`define PDCC_SCL_MSB       27
`define PDCC_ROLE_BASED_ERR_SUPPORT_RST     1'h1
`define PDCC_DEVCAP_LOW    13'h0000
`define PDCC_CTL_RST       3'h0
`define PDCC_STS_RST       3'h0
`define PDCC_MASK_RST      3'h0
`endif

// ===== pkg/pdcc_pkg.sv
// Types shared by the device capability and control block
package pdcc_pkg;
   typedef enum logic [1:0] {
      PDCC_PORT_UPSTREAM,
      PDCC_PORT_DOWNSTREAM,
      PDCC_PORT_UNATTACHED
   } pdcc_port_mode_t;
   typedef enum logic [1:0] {
      PDCC_SCALE_1_0,
      PDCC_SCALE_0_1,
      PDCC_SCALE_0_01,
      PDCC_SCALE_0_001
   } pdcc_scale_t;
endpackage

// ===== tb/pdcc_msg_src.sv
// Upstream link partner model that sends slot power limit messages
`timescale 1ns/1ns
`default_nettype none
module pdcc_msg_src (
   input  wire logic             clk,
   output logic                  msg_valid,
   output logic [7:0]            msg_value,
   output pdcc_pkg::pdcc_scale_t msg_scale
);
   // Quiet link at time zero
   initial begin
      msg_valid = 1'h0;
      msg_value = 8'h00;
      msg_scale = pdcc_pkg::PDCC_SCALE_1_0;
   end
   // One message; contents go stale (inverted) once valid drops
   task automatic send(input logic [7:0] v, input logic [1:0] s);
      @(posedge clk);
      msg_valid <= 1'h1;
      msg_value <= v;
      msg_scale <= pdcc_pkg::pdcc_scale_t'(s);
      @(posedge clk);
      msg_valid <= 1'h0;
      msg_value <= ~v;
      msg_scale <= pdcc_pkg::pdcc_scale_t'(~s);
   endtask
endmodule
`default_nettype wire

// ===== tb/pdcc_regs_tb.sv
// Self-checking bench of the capability and control register bank
`timescale 1ns/1ns
`default_nettype none
`include "pdcc_params.svh"
module pdcc_regs_tb;
   logic                      clk, rst, reg_wr, reg_rd, irq, msg_valid, rd_q;
   logic [11:0]               reg_addr;
   logic [31:0]               reg_wdata, reg_rdata;
   pdcc_pkg::pdcc_port_mode_t port_mode;
   pdcc_pkg::pdcc_scale_t     msg_scale, pls;
   logic [7:0]                msg_value, plv, v;
   logic [2:0]                err_event, err_report, en;
   logic [1:0]                s;
   logic [13:0]               obs;
   logic [31:0]               exp_q[$];
   int                        error_cnt, cmp_count, cyc, i, j;
   int unsigned               seed;
   assign obs = {irq, err_report, pls, plv};
   pdcc_regs #(.VAL_W(8)) pdcc_regs_inst (.clk(clk), .rst(rst),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .port_mode(port_mode),
      .msg_valid(msg_valid), .msg_value(msg_value), .msg_scale(msg_scale),
      .err_event(err_event), .err_report(err_report),
      .power_limit_value(plv), .power_limit_scale(pls), .irq(irq));
   pdcc_msg_src pdcc_msg_src_inst (.clk(clk), .msg_valid(msg_valid),
      .msg_value(msg_value), .msg_scale(msg_scale));
   // Capability word expected for an upstream port
   function automatic logic [31:0] capw(input logic [7:0] fv,
                                        input logic [1:0] fs);
      return {4'h0, fs, fv, 18'h08000};
   endfunction
   task automatic bad(input string m);
      error_cnt++;
      $display("BAD %0t %s", $time, m);
   endtask
   task automatic chk_rd(input logic [31:0] g, input logic [31:0] e);
      cmp_count++;
      if (g !== e)
         bad($sformatf("read %h expected %h", g, e));
   endtask
   task automatic chk_out(input logic [13:0] g, input logic [13:0] e);
      cmp_count++;
      if (g !== e)
         bad($sformatf("outputs %h expected %h", g, e));
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_wr <= 1'h1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'h0;
   endtask
   // Read strobe plus a note of the word expected next cycle
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      @(posedge clk);
      reg_rd <= 1'h1;
      reg_addr <= a;
      exp_q.push_back(e);
      @(posedge clk);
      reg_rd <= 1'h0;
   endtask
   // Write then read one address on back-to-back strobes
   task automatic wr_rd(input logic [11:0] a, input logic [31:0] d,
                        input logic [31:0] e);
      @(posedge clk);
      reg_wr <= 1'h1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'h0;
      reg_rd <= 1'h1;
      exp_q.push_back(e);
      @(posedge clk);
      reg_rd <= 1'h0;
   endtask
   task automatic tally_and_finish;
      $display("Comparisons %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // Clock generator
   initial begin
      clk = 1'h0;
      forever #4 clk = ~clk;
   end
   // Read monitor and hang limit
   always @(posedge clk) begin
      if (rd_q === 1'h1)
         chk_rd(reg_rdata, exp_q.pop_front());
      rd_q <= reg_rd;
      cyc++;
      if (cyc == 5000) begin
         bad("timeout");
         tally_and_finish();
      end
   end
   // Main sequence
   initial begin
      rst = 1'h1;
      {reg_wr, reg_rd, reg_addr, reg_wdata} = 46'h0;
      port_mode = pdcc_pkg::PDCC_PORT_UPSTREAM;
      err_event = 3'h0;
      seed = $urandom(43);
      repeat (10) @(posedge clk);
      rst <= 1'h0;
      rd(`PDCC_OFF_DEVCAP, 32'h00008000);
      rd(`PDCC_OFF_DEVCTL, 32'h0);
      wr(`PDCC_OFF_DEVCAP, 32'hffffffff);
      rd(`PDCC_OFF_DEVCAP, 32'h00008000);
      rd(12'h100, 32'h0);
      $display("Test reset values done");
      wr(`PDCC_OFF_IRQMASK, 32'h8);
      for (i = 0; i < 4; i++) begin
         v = 8'($urandom);
         s = 2'(i);
         pdcc_msg_src_inst.send(v, s);
         @(negedge clk);
         chk_out(obs, {4'h0, s, v});
         rd(`PDCC_OFF_DEVCAP, capw(v, s));
         @(negedge clk);
         chk_out(obs, {4'h8, s, v});
         wr(`PDCC_OFF_ERRSTS, 32'h8);
         // Interrupt level lags the cleared flag by one cycle
         repeat (2) @(negedge clk);
         chk_out(obs, {4'h0, s, v});
      end
      $display("Test power messages done");
      wr(`PDCC_OFF_ERRSTS, 32'hf);
      en = 3'($urandom);
      for (j = 0; j < 2; j++) begin
         wr_rd(`PDCC_OFF_DEVCTL, {29'h0, en},
               {29'h0, en});
         for (i = 1; i < 8; i++) begin
            @(posedge clk);
            err_event <= 3'(i);
            @(posedge clk);
            err_event <= 3'h0;
            @(negedge clk);
            chk_out(obs, {1'h0, 3'(i) & en, s, v});
         end
         en = ~en;
      end
      rd(`PDCC_OFF_ERRSTS, 32'h7);
      // Clear and a new correctable event in one cycle: the event wins
      @(posedge clk);
      reg_wr <= 1'h1;
      reg_addr <= `PDCC_OFF_ERRSTS;
      reg_wdata <= 32'h7;
      err_event <= 3'h1;
      @(posedge clk);
      reg_wr <= 1'h0;
      err_event <= 3'h0;
      rd(`PDCC_OFF_ERRSTS, 32'h1);
      $display("Test error enables done");
      @(posedge clk);
      port_mode <= pdcc_pkg::PDCC_PORT_DOWNSTREAM;
      rd(`PDCC_OFF_DEVCAP, 32'h00008000);
      @(posedge clk);
      port_mode <= pdcc_pkg::PDCC_PORT_UNATTACHED;
      pdcc_msg_src_inst.send(8'h5a, 2'h1);
      rd(`PDCC_OFF_DEVCAP, 32'h00008000);
      rd(`PDCC_OFF_PORTSTAT, 32'h2);
      @(posedge clk);
      port_mode <= pdcc_pkg::PDCC_PORT_UPSTREAM;
      rd(`PDCC_OFF_DEVCAP, 32'h00008000);
      pdcc_msg_src_inst.send(8'hff, 2'h3);
      rd(`PDCC_OFF_DEVCAP, capw(8'hff, 2'h3));
      $display("Test port modes done");
      repeat (2) @(posedge clk);
      tally_and_finish();
   end
endmodule
`default_nettype wire
